/* File: hdl/plr_port1_regs.sv */
// port-1 register set: low-power and serial control, role and charge status,
// high-speed transmit adjust, reached over AXI4-Lite
// assumes status inputs and pins are synchronous to aclk; fuse values are
// stable and qualified by fuse_valid when reset is released
//
// Behaviour
// - bit 6: host frame-based sleep enable, read-write, resets to one
// - bit 5: peripheral frame-based sleep enable, read-write, resets to zero
// - bit 4: response-based sleep enable, resets to one, clear blocks entry
// - bit 3: pin polarity, zero means high pin enables serial mode
// - bit 2: D+ pull-up applied during serial mode when set
// - bit 1: serial enable source, zero register bit, one general pin
// - bit 0: register serial pass-through enable when pin source not chosen
// - fuse-defaulted fields may take factory fuse values instead of defaults
// - bits 4-3: read-only port role: none, host, peripheral, reserved
// - bit 0: charge primary detect, zero detected, when method two enabled
// - bits 7-6: termination code, default one
// - bits 3-0: transmit swing code, default seven
// - during chirp J or K the swing code is ignored for fixed amplitude
`timescale 1ns/100ps
`default_nettype none
module plr_port1_regs
    import plr_pkg::*;
(
    input wire logic aclk, // system clock, 200 MHz
    input wire logic aresetn, // sync reset, active low
    input wire logic [AXI_AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [AXI_AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic fuse_valid, // fuse values programmed
    input wire logic [7:0] fuse_lp_uart_ctrl, // fuse default, control register
    input wire logic [7:0] fuse_tx_adjust, // fuse default, transmit adjust
    input wire logic [1:0] port_role_status, // role from repeater core
    input wire logic charge_primary_detect_status, // raw detect, 0 = detected
    input wire logic charge_method_two_enable, // charge method two active
    input wire logic chirp_active, // chirp J or K being sent
    input wire logic general_pin_one, // general pin level
    output logic host_frame_sleep_enable, // host frame sleep allowed
    output logic periph_frame_sleep_enable, // peripheral frame sleep allowed
    output logic response_sleep_enable, // response sleep allowed
    output logic serial_mode_active, // serial pass-through on
    output logic serial_dplus_pullup_on, // D+ pull-up on
    output logic [1:0] hs_termination_code, // termination setting
    output logic [1:0] hs_tx_edge_rate_code, // edge-rate setting
    output logic [3:0] hs_tx_swing_code, // swing applied to the driver
    output logic hs_tx_chirp_swing // fixed chirp amplitude in use
);

    plr_regbus_if rb ();

    logic [7:0] lp_ctrl_ff;
    logic [7:0] tx_adj_ff;
    logic spare_rw_ff;
    logic [1:0] role_ff;
    logic charge_ff;
    logic fuse_load_ff;
    logic wr_lp;
    logic wr_role;
    logic wr_tx;
    logic [7:0] wbyte;
    logic [7:0] role_charge_view;

    // ***********************************
    // bus slave
    // ***********************************
    plr_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rb(rb.slave_side)
    );

    // ***********************************
    // address decode
    // ***********************************
    // only byte lane 0 carries register bits; other lanes are ignored
    assign wbyte = rb.wdata[7:0];
    assign wr_lp = rb.wr_en && rb.wstrb[0] && (rb.waddr == OFS_LP_UART_CTRL);
    assign wr_role = rb.wr_en && rb.wstrb[0] && (rb.waddr == OFS_ROLE_CHARGE);
    assign wr_tx = rb.wr_en && rb.wstrb[0] && (rb.waddr == OFS_TX_ADJUST);

    always_comb begin
        case (rb.waddr)
            OFS_LP_UART_CTRL: rb.wr_hit = 1'b1;
            OFS_ROLE_CHARGE: rb.wr_hit = 1'b1;
            OFS_TX_ADJUST: rb.wr_hit = 1'b1;
            default: rb.wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        role_charge_view = 8'h00;
        role_charge_view[BIT_ROLE_RW_SPARE] = spare_rw_ff;
        role_charge_view[POS_ROLE_LO +: 2] = role_ff;
        role_charge_view[BIT_CHARGE_DETECT] = charge_ff;
    end

    always_comb begin
        rb.rdata = 32'h0000_0000;
        rb.rd_hit = 1'b1;
        case (rb.raddr)
            OFS_LP_UART_CTRL: rb.rdata[7:0] = lp_ctrl_ff & MASK_LP_UART_CTRL;
            OFS_ROLE_CHARGE: rb.rdata[7:0] = role_charge_view;
            OFS_TX_ADJUST: rb.rdata[7:0] = tx_adj_ff;
            default: rb.rd_hit = 1'b0;
        endcase
    end

    // ***********************************
    // fuse default load
    // ***********************************
    // one cycle after reset release the fuse image may replace the defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_load_ff <= 1'b1;
        end else begin
            fuse_load_ff <= 1'b0;
        end
    end

    // ***********************************
    // low-power and serial control
    // ***********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lp_ctrl_ff <= RST_LP_UART_CTRL;
        end else if (fuse_load_ff && fuse_valid) begin
            lp_ctrl_ff <= fuse_lp_uart_ctrl & MASK_LP_UART_CTRL;
        end else if (wr_lp) begin
            lp_ctrl_ff <= wbyte & MASK_LP_UART_CTRL;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_frame_sleep_enable <= RST_LP_UART_CTRL[BIT_HOST_FRAME_SLEEP];
            periph_frame_sleep_enable <= RST_LP_UART_CTRL[BIT_PERIPH_FRAME_SLEEP];
            response_sleep_enable <= RST_LP_UART_CTRL[BIT_RESPONSE_SLEEP];
        end else begin
            host_frame_sleep_enable <= lp_ctrl_ff[BIT_HOST_FRAME_SLEEP];
            periph_frame_sleep_enable <= lp_ctrl_ff[BIT_PERIPH_FRAME_SLEEP];
            response_sleep_enable <= lp_ctrl_ff[BIT_RESPONSE_SLEEP];
        end
    end

    plr_serial_sel u_serial (
        .aclk(aclk),
        .aresetn(aresetn),
        .serial_passthrough_enable(lp_ctrl_ff[BIT_SERIAL_ENABLE]),
        .serial_enable_source(lp_ctrl_ff[BIT_SERIAL_SOURCE]),
        .serial_pin_polarity(lp_ctrl_ff[BIT_SERIAL_POLARITY]),
        .serial_dplus_pullup_enable(lp_ctrl_ff[BIT_SERIAL_PULLUP]),
        .general_pin_one(general_pin_one),
        .serial_active_ff(serial_mode_active),
        .dplus_pullup_ff(serial_dplus_pullup_on)
    );

    // ***********************************
    // role and charge status
    // ***********************************
    // status fields follow hardware only; bus writes reach just the spare bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spare_rw_ff <= RST_ROLE_CHARGE[BIT_ROLE_RW_SPARE];
        end else if (wr_role) begin
            spare_rw_ff <= wbyte[BIT_ROLE_RW_SPARE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            role_ff <= RST_ROLE_CHARGE[POS_ROLE_LO +: 2];
        end else begin
            role_ff <= port_role_status;
        end
    end

    // without method two the result stays at not detected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            charge_ff <= RST_ROLE_CHARGE[BIT_CHARGE_DETECT];
        end else if (charge_method_two_enable) begin
            charge_ff <= charge_primary_detect_status;
        end else begin
            charge_ff <= CHARGE_NOT_DETECTED;
        end
    end

    // ***********************************
    // high-speed transmit adjust
    // ***********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_adj_ff <= RST_TX_ADJUST;
        end else if (fuse_load_ff && fuse_valid) begin
            tx_adj_ff <= fuse_tx_adjust;
        end else if (wr_tx) begin
            tx_adj_ff <= wbyte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_termination_code <= RST_TX_ADJUST[POS_TERM_LO +: 2];
            hs_tx_edge_rate_code <= RST_TX_ADJUST[POS_EDGE_LO +: 2];
        end else begin
            hs_termination_code <= tx_adj_ff[POS_TERM_LO +: 2];
            hs_tx_edge_rate_code <= tx_adj_ff[POS_EDGE_LO +: 2];
        end
    end

    // chirp overrides the programmed swing so chirp levels stay fixed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_tx_swing_code <= RST_TX_ADJUST[POS_SWING_LO +: 4];
            hs_tx_chirp_swing <= 1'b0;
        end else if (chirp_active) begin
            hs_tx_swing_code <= SWING_CHIRP_FIXED;
            hs_tx_chirp_swing <= 1'b1;
        end else begin
            hs_tx_swing_code <= tx_adj_ff[POS_SWING_LO +: 4];
            hs_tx_chirp_swing <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: shared/plr_pkg.sv */
// constants for the port-1 low-power, serial and transmit register set
// assumes an 8-bit AXI4-Lite byte address space, 32-bit data
package plr_pkg;

    // ***********************************
    // bus and response codes
    // ***********************************
    localparam int AXI_AW = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ***********************************
    // register byte offsets
    // ***********************************
    localparam logic [7:0] OFS_LP_UART_CTRL = 8'h50;
    localparam logic [7:0] OFS_ROLE_CHARGE = 8'h60;
    localparam logic [7:0] OFS_TX_ADJUST = 8'h70;

    // ***********************************
    // values after reset
    // ***********************************
    localparam logic [7:0] RST_LP_UART_CTRL = 8'h50;
    localparam logic [7:0] RST_ROLE_CHARGE = 8'h00;
    localparam logic [7:0] RST_TX_ADJUST = 8'h77;

    // ***********************************
    // low-power and serial control fields
    // ***********************************
    localparam int BIT_HOST_FRAME_SLEEP = 6;
    localparam int BIT_PERIPH_FRAME_SLEEP = 5;
    localparam int BIT_RESPONSE_SLEEP = 4;
    localparam int BIT_SERIAL_POLARITY = 3;
    localparam int BIT_SERIAL_PULLUP = 2;
    localparam int BIT_SERIAL_SOURCE = 1;
    localparam int BIT_SERIAL_ENABLE = 0;
    localparam logic [7:0] MASK_LP_UART_CTRL = 8'h7f;

    // ***********************************
    // role and charge status fields
    // ***********************************
    localparam int BIT_ROLE_RW_SPARE = 7;
    localparam int POS_ROLE_LO = 3;
    localparam int BIT_CHARGE_DETECT = 0;
    localparam logic CHARGE_NOT_DETECTED = 1'h1;

    // ***********************************
    // transmit adjust fields
    // ***********************************
    localparam int POS_TERM_LO = 6;
    localparam int POS_EDGE_LO = 4;
    localparam int POS_SWING_LO = 0;
    localparam logic [3:0] SWING_CHIRP_FIXED = 4'h3;

endpackage

/* File: shared/plr_regbus_if.sv */
// register access strobes between the bus slave and the register set
// assumes both ends share aclk
`timescale 1ns/100ps
`default_nettype none
interface plr_regbus_if;
    import plr_pkg::*;
    logic wr_en;
    logic [AXI_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wr_hit;
    logic [AXI_AW-1:0] raddr;
    logic [31:0] rdata;
    logic rd_hit;

    modport slave_side (
        output wr_en, waddr, wdata, wstrb, raddr,
        input wr_hit, rdata, rd_hit
    );
    modport reg_side (
        input wr_en, waddr, wdata, wstrb, raddr,
        output wr_hit, rdata, rd_hit
    );
endinterface
`default_nettype wire

/* File: hdl/plr_axil_slave.sv */
// AXI4-Lite slave: one write and one read at a time, registered handshakes
// assumes the register side decodes addresses combinationally
`timescale 1ns/100ps
`default_nettype none
module plr_axil_slave
    import plr_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [AXI_AW-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [AXI_AW-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    plr_regbus_if.slave_side rb // register side
);

    logic [AXI_AW-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_write;

    // write fires once both halves are held and no response is pending
    assign do_write = !awready && !wready && !bvalid;
    assign rb.wr_en = do_write;
    assign rb.waddr = awaddr_ff;
    assign rb.wdata = wdata_ff;
    assign rb.wstrb = wstrb_ff;
    assign rb.raddr = araddr;

    // ***********************************
    // write channels
    // ***********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            awaddr_ff <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            awaddr_ff <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ***********************************
    // read channels
    // ***********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rb.rdata;
            rresp <= rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: hdl/plr_serial_sel.sv */
// resolves the serial pass-through enable and the D+ pull-up request
// assumes the general pin is already synchronous to aclk
`timescale 1ns/100ps
`default_nettype none
module plr_serial_sel (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic serial_passthrough_enable, // register enable
    input wire logic serial_enable_source, // 1 selects the pin
    input wire logic serial_pin_polarity, // 1 means pin low enables
    input wire logic serial_dplus_pullup_enable, // pull-up during serial mode
    input wire logic general_pin_one, // general pin level
    output logic serial_active_ff, // serial pass-through on
    output logic dplus_pullup_ff // D+ pull-up on
);

    logic pin_req;
    logic nxt_active;

    assign pin_req = general_pin_one ^ serial_pin_polarity;
    assign nxt_active = serial_enable_source ? pin_req : serial_passthrough_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_active_ff <= 1'b0;
            dplus_pullup_ff <= 1'b0;
        end else begin
            serial_active_ff <= nxt_active;
            dplus_pullup_ff <= nxt_active && serial_dplus_pullup_enable;
        end
    end

endmodule
`default_nettype wire

/* File: verif/plr_port1_properties.sv */
// checker for the port-1 register set: bus answers, chirp swing, pull-up
// assumes it is bound to plr_port1_regs and shares its clock and reset
`timescale 1ns/100ps
`default_nettype none
module plr_port1_properties
    import plr_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic [AXI_AW-1:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [AXI_AW-1:0] s_axi_araddr, // ar addr
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r resp
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic chirp_active, // chirp sent
    input wire logic [3:0] hs_tx_swing_code, // swing out
    input wire logic hs_tx_chirp_swing, // chirp flag
    input wire logic serial_mode_active, // serial on
    input wire logic serial_dplus_pullup_on // pull-up on
);
    // ***********************************
    // helpers
    // ***********************************
    function automatic logic [1:0] resp_for(input logic [7:0] a);
        return (a == OFS_LP_UART_CTRL || a == OFS_ROLE_CHARGE || a == OFS_TX_ADJUST) ? RESP_OKAY : RESP_SLVERR;
    endfunction

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ***********************************
    // assertions
    // ***********************************
    wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid && s_axi_bresp == resp_for($past(s_axi_awaddr, 2)))
        else $error("write answer missing or wrong code");
    rd_resp_a: assert property (rd_taken |=> s_axi_rvalid && s_axi_rresp == resp_for($past(s_axi_araddr)))
        else $error("read answer missing or wrong code");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    ctrl_spare_a: assert property (rd_taken ##0 s_axi_araddr == OFS_LP_UART_CTRL |=> !s_axi_rdata[7])
        else $error("control bit 7 reads one");
    chirp_swing_a: assert property (chirp_active |=> hs_tx_chirp_swing && hs_tx_swing_code == SWING_CHIRP_FIXED)
        else $error("chirp swing not fixed");
    chirp_off_a: assert property (!chirp_active |=> !hs_tx_chirp_swing)
        else $error("chirp flag without chirp");
    pullup_gate_a: assert property (serial_dplus_pullup_on |-> serial_mode_active)
        else $error("pull-up outside serial mode");
    reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> s_axi_awready && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus not idle after reset");
endmodule

bind plr_port1_regs plr_port1_properties u_props (.*);
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the port-1 register set over AXI4-Lite
// assumes the design package and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench
    import plr_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fuse_valid, charge_primary_detect_status;
    logic charge_method_two_enable, chirp_active, general_pin_one, host_frame_sleep_enable;
    logic periph_frame_sleep_enable, response_sleep_enable, serial_mode_active, serial_dplus_pullup_on;
    logic hs_tx_chirp_swing;
    logic [7:0] s_axi_awaddr, s_axi_araddr, fuse_lp_uart_ctrl, fuse_tx_adjust;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, hs_tx_swing_code;
    logic [1:0] s_axi_bresp, s_axi_rresp, port_role_status, hs_termination_code, hs_tx_edge_rate_code;
    int errors = 0;
    int n_compared = 0;

    plr_port1_regs DUT (.*);

    // ***********************************
    // bus tasks
    // ***********************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        `CHK(r, RESP_OKAY)
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK(r, RESP_OKAY)
        `CHK(d, exp)
    endtask

    // outputs follow registers and inputs one edge later
    task automatic settle();
        repeat (2) @(posedge aclk);
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // ***********************************
    // scenarios
    // ***********************************
    task automatic t_reset();
        chk_rd(OFS_LP_UART_CTRL, 32'h50);
        chk_rd(OFS_ROLE_CHARGE, 32'h0);
        chk_rd(OFS_TX_ADJUST, 32'h77);
        `CHK({host_frame_sleep_enable, periph_frame_sleep_enable, response_sleep_enable}, 3'b101)
        `CHK({hs_termination_code, hs_tx_edge_rate_code, hs_tx_swing_code}, 8'h77)
        $display("test reset values done");
    endtask

    task automatic t_sleep();
        wr_ok(OFS_LP_UART_CTRL, 32'hff);
        chk_rd(OFS_LP_UART_CTRL, 32'h7f);
        `CHK({host_frame_sleep_enable, periph_frame_sleep_enable, response_sleep_enable}, 3'b111)
        wr_ok(OFS_LP_UART_CTRL, 32'h20);
        chk_rd(OFS_LP_UART_CTRL, 32'h20);
        `CHK({host_frame_sleep_enable, periph_frame_sleep_enable, response_sleep_enable}, 3'b010)
        $display("test sleep enables done");
    endtask

    task automatic t_serial();
        logic act;
        for (int i = 0; i < 32; i++) begin
            general_pin_one <= i[4];
            wr_ok(OFS_LP_UART_CTRL, {28'h0, i[3:0]});
            settle();
            act = i[1] ? (i[4] ^ i[3]) : i[0];
            `CHK(serial_mode_active, act)
            `CHK(serial_dplus_pullup_on, act & i[2])
        end
        $display("test serial select done");
    endtask

    task automatic t_status();
        for (int r = 0; r < 4; r++) begin
            port_role_status <= r[1:0];
            charge_primary_detect_status <= r[0];
            settle();
            chk_rd(OFS_ROLE_CHARGE, {24'h0, 3'h0, r[1:0], 2'h0, r[0]});
        end
        charge_method_two_enable <= 1'b0;
        charge_primary_detect_status <= 1'b0;
        wr_ok(OFS_ROLE_CHARGE, 32'hff);
        chk_rd(OFS_ROLE_CHARGE, 32'h99);
        wr_ok(OFS_ROLE_CHARGE, 32'h0);
        charge_method_two_enable <= 1'b1;
        $display("test status done");
    endtask

    task automatic t_txadj();
        logic [31:0] d;
        logic [1:0] r;
        wr_ok(OFS_TX_ADJUST, 32'h9e);
        chk_rd(OFS_TX_ADJUST, 32'h9e);
        `CHK({hs_termination_code, hs_tx_edge_rate_code, hs_tx_swing_code}, 8'h9e)
        chirp_active <= 1'b1;
        settle();
        `CHK({hs_tx_chirp_swing, hs_tx_swing_code}, {1'b1, SWING_CHIRP_FIXED})
        chirp_active <= 1'b0;
        settle();
        `CHK({hs_tx_chirp_swing, hs_tx_swing_code}, 5'h0e)
        wr(8'h54, 32'h1, r);
        `CHK(r, RESP_SLVERR)
        rd(8'h71, d, r);
        `CHK({r, d}, {RESP_SLVERR, 32'h0})
        $display("test transmit adjust done");
    endtask

    task automatic t_fuse();
        fuse_valid <= 1'b1;
        fuse_lp_uart_ctrl <= 8'hab;
        fuse_tx_adjust <= 8'h3c;
        do_reset();
        chk_rd(OFS_LP_UART_CTRL, 32'h2b);
        chk_rd(OFS_TX_ADJUST, 32'h3c);
        `CHK({host_frame_sleep_enable, periph_frame_sleep_enable, response_sleep_enable}, 3'b010)
        fuse_valid <= 1'b0;
        do_reset();
        chk_rd(OFS_LP_UART_CTRL, 32'h50);
        $display("test fuse defaults done");
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ***********************************
    // clock, watchdog, main sequence
    // ***********************************
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial begin
        #50000;
        errors++;
        wrap_up();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
        {fuse_valid, fuse_lp_uart_ctrl, fuse_tx_adjust, port_role_status} = 19'h0;
        {charge_primary_detect_status, chirp_active, general_pin_one} = 3'h0;
        charge_method_two_enable = 1'b1;
        do_reset();
        t_reset();
        t_sleep();
        t_serial();
        t_status();
        t_txadj();
        t_fuse();
        wrap_up();
    end
endmodule
`default_nettype wire
